// [core/acmp_comparator.sv]
// Behavioural model of the comparator core with its input selection.
// Assumes levels are steady analog codes; output is asynchronous.
`timescale 1ns/1ps
module acmp_comparator
  import acmp_pkg::*;
(
  // Analog side
  input  wire acmp_analog_s analog_i,
  // Selection
  input  wire acmp_sel_s    sel_i,
  // Raw result
  output logic              raw_o
);

  // ----------------------------------------------------------------------
  // Input selection and compare
  // ----------------------------------------------------------------------
  logic [9:0] pos_sel;
  logic [9:0] neg_sel;

  // Mux path only while the converter is off
  always_comb
  begin
    pos_sel = sel_i.bandgap_select ? ACMP_BANDGAP_LVL
                                   : analog_i.pos_level;
    if (sel_i.neg_input_mux_enable && !sel_i.converter_enable)
      neg_sel = analog_i.chan_level[sel_i.channel_select];
    else
      neg_sel = analog_i.neg_level;
    // Powered-down core reads low, like an idle output
    raw_o = !sel_i.power_off && (pos_sel > neg_sel);
  end

endmodule : acmp_comparator

// [core/acmp_pkg.sv]
// Shared constants and carriers for the analog comparator control block.
// Assumes a 32-bit classic Wishbone slave port and a single system clock.
package acmp_pkg;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ACMP_OFS_CTRL_STATUS = 8'h50;
  localparam logic [7:0] ACMP_OFS_CONV_CSR_B  = 8'h54;
  localparam logic [7:0] ACMP_OFS_DIG_IN_DIS  = 8'h58;
  localparam logic [7:0] ACMP_OFS_CONV_BORROW = 8'h5c;
  localparam logic [7:0] ACMP_OFS_IRQ_STATUS  = 8'h60;
  localparam logic [7:0] ACMP_OFS_IRQ_MASK    = 8'h64;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int ACMP_BIT_POWER_OFF   = 7;
  localparam int ACMP_BIT_BANDGAP     = 6;
  localparam int ACMP_BIT_RESULT      = 5;
  localparam int ACMP_BIT_EVENT_FLAG  = 4;
  localparam int ACMP_BIT_IRQ_ENABLE  = 3;
  localparam int ACMP_BIT_CAPTURE     = 2;
  localparam int ACMP_BIT_MODE_HI     = 1;
  localparam int ACMP_BIT_NEG_MUX_EN  = 6;
  localparam int ACMP_BIT_CONV_EN     = 7;
  localparam int ACMP_BIT_CONV_PRR    = 6;
  localparam int ACMP_BIT_IRQ_EVENT   = 0;

  // ----------------------------------------------------------------------
  // Reset values and analog constants
  // ----------------------------------------------------------------------
  localparam logic [7:0] ACMP_RST_REG8    = 8'h00;
  localparam logic [9:0] ACMP_BANDGAP_LVL = 10'h0e1;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ACMP_EV_TOGGLE,
    ACMP_EV_RESERVED,
    ACMP_EV_FALL,
    ACMP_EV_RISE
  } acmp_mode_e;

  typedef struct packed {
    logic [9:0]      pos_level;
    logic [9:0]      neg_level;
    logic [7:0][9:0] chan_level;
  } acmp_analog_s;

  typedef struct packed {
    logic            power_off;
    logic            bandgap_select;
    logic            neg_input_mux_enable;
    logic            converter_enable;
    logic [2:0]      channel_select;
  } acmp_sel_s;

endpackage : acmp_pkg

// [core/acmp_sync.sv]
// Two-stage synchroniser for asynchronous levels into the system clock.
// Assumes inputs may change at any time relative to clk_i.
`timescale 1ns/1ps
module acmp_sync
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Levels
  input  wire logic [2:0] async_i,
  output logic      [2:0] sync_o
);

  // ----------------------------------------------------------------------
  // Double flop; first stage feeds only the second
  // ----------------------------------------------------------------------
  logic [2:0] meta;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta   <= 3'h0;
      sync_o <= 3'h0;
    end
    else
    begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end

endmodule : acmp_sync

// [core/acmp_top.sv]
// Analog comparator control: registers, input select, sync, events, irq.
// Assumes a classic Wishbone master on clk_i; analog levels arrive as
// codes and the processor pulses irq_vector_ack_i on vector entry.
`timescale 1ns/1ps
module acmp_top
  import acmp_pkg::*;
(
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Wishbone slave
  input  wire logic         cyc_i,
  input  wire logic         stb_i,
  input  wire logic         we_i,
  input  wire logic [7:0]   adr_i,
  input  wire logic [3:0]   sel_i,
  input  wire logic [31:0]  dat_i,
  output logic      [31:0]  dat_o,
  output logic              ack_o,
  // Analog inputs
  input  wire acmp_analog_s analog_i,
  // Pin digital levels
  input  wire logic         pos_pin_digital_i,
  input  wire logic         neg_pin_digital_i,
  output logic      [1:0]   port_pin_read_o,
  output logic      [1:0]   input_buffer_disable_o,
  // Processor interrupt
  input  wire logic         global_irq_enable_i,
  input  wire logic         irq_vector_ack_i,
  output logic              irq_o,
  // Timer capture and power
  output logic              capture_trigger_o,
  output logic              comparator_powered_o,
  output logic              converter_power_reduce_o
);

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic       power_off;
  logic       bandgap_select;
  logic       compare_event_flag;
  logic       compare_irq_enable;
  logic       capture_route_enable;
  acmp_mode_e compare_event_mode;
  logic       neg_input_mux_enable;
  logic [1:0] input_buffer_disable;
  logic       converter_enable;
  logic       converter_power_reduce;
  logic [2:0] channel_select;
  logic       irq_mask;
  logic       compare_result;
  logic       result_prev;
  logic       raw_result;
  logic [2:0] synced;
  logic       wr_lo;
  logic       hit_edge;
  logic [7:0] next_rdata;

  // Byte lane 0 write, taken on the acknowledged cycle
  function automatic logic wr_at(input logic [7:0] ofs);
    wr_at = wr_lo && (adr_i == ofs);
  endfunction : wr_at

  assign wr_lo = cyc_i && stb_i && we_i && ack_o && sel_i[0];

  // ----------------------------------------------------------------------
  // Analog core and synchronisers
  // ----------------------------------------------------------------------
  acmp_sel_s core_sel;

  assign core_sel = '{power_off:            power_off,
                      bandgap_select:       bandgap_select,
                      neg_input_mux_enable: neg_input_mux_enable,
                      converter_enable:     converter_enable,
                      channel_select:       channel_select};

  acmp_comparator u_core (
    .analog_i (analog_i),
    .sel_i    (core_sel),
    .raw_o    (raw_result)
  );

  acmp_sync u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i ({neg_pin_digital_i, pos_pin_digital_i, raw_result}),
    .sync_o  (synced)
  );

  assign compare_result = synced[0];

  // ----------------------------------------------------------------------
  // Wishbone handshake
  // ----------------------------------------------------------------------
  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_o <= 1'b0;
    else
      ack_o <= cyc_i && stb_i && !ack_o;
  end

  // Read mux; unmapped offsets read zero
  always_comb
  begin
    next_rdata = 8'h00;
    case (adr_i)
      ACMP_OFS_CTRL_STATUS: next_rdata = {power_off, bandgap_select,
                                          compare_result,
                                          compare_event_flag,
                                          compare_irq_enable,
                                          capture_route_enable,
                                          compare_event_mode};
      ACMP_OFS_CONV_CSR_B:  next_rdata = {1'b0, neg_input_mux_enable, 6'h00};
      ACMP_OFS_DIG_IN_DIS:  next_rdata = {6'h00, input_buffer_disable};
      ACMP_OFS_CONV_BORROW: next_rdata = {converter_enable,
                                          converter_power_reduce,
                                          3'h0, channel_select};
      ACMP_OFS_IRQ_STATUS:  next_rdata = {7'h00, compare_event_flag};
      ACMP_OFS_IRQ_MASK:    next_rdata = {7'h00, irq_mask};
      default:              next_rdata = 8'h00;
    endcase
  end

  // Read data latched with the ack
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= 32'h0;
    else if (cyc_i && stb_i && !ack_o && !we_i)
      dat_o <= {24'h0, next_rdata};
  end

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  // Control fields of the compare register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      power_off            <= 1'b0;
      bandgap_select       <= 1'b0;
      compare_irq_enable   <= 1'b0;
      capture_route_enable <= 1'b0;
      compare_event_mode   <= ACMP_EV_TOGGLE;
    end
    else if (wr_at(ACMP_OFS_CTRL_STATUS))
    begin
      power_off            <= dat_i[ACMP_BIT_POWER_OFF];
      bandgap_select       <= dat_i[ACMP_BIT_BANDGAP];
      compare_irq_enable   <= dat_i[ACMP_BIT_IRQ_ENABLE];
      capture_route_enable <= dat_i[ACMP_BIT_CAPTURE];
      compare_event_mode   <= acmp_mode_e'(dat_i[ACMP_BIT_MODE_HI:0]);
    end
  end

  // Mux enable, buffer disables, borrowed converter bits, mask
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      neg_input_mux_enable   <= 1'b0;
      input_buffer_disable   <= 2'h0;
      converter_enable       <= 1'b0;
      converter_power_reduce <= 1'b0;
      channel_select         <= 3'h0;
      irq_mask               <= 1'b1;
    end
    else
    begin
      if (wr_at(ACMP_OFS_CONV_CSR_B))
        neg_input_mux_enable <= dat_i[ACMP_BIT_NEG_MUX_EN];
      if (wr_at(ACMP_OFS_DIG_IN_DIS))
        input_buffer_disable <= dat_i[1:0];
      if (wr_at(ACMP_OFS_CONV_BORROW))
      begin
        converter_enable       <= dat_i[ACMP_BIT_CONV_EN];
        converter_power_reduce <= dat_i[ACMP_BIT_CONV_PRR];
        channel_select         <= dat_i[2:0];
      end
      if (wr_at(ACMP_OFS_IRQ_MASK))
        irq_mask <= dat_i[ACMP_BIT_IRQ_EVENT];
    end
  end

  // ----------------------------------------------------------------------
  // Event detection and flag
  // ----------------------------------------------------------------------
  // Previous result for edge finding
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      result_prev <= 1'b0;
    else
      result_prev <= compare_result;
  end

  // Edge qualified by mode; reserved code never fires
  always_comb
  begin
    case (compare_event_mode)
      ACMP_EV_TOGGLE: hit_edge = compare_result != result_prev;
      ACMP_EV_FALL:   hit_edge = result_prev && !compare_result;
      ACMP_EV_RISE:   hit_edge = !result_prev && compare_result;
      default:        hit_edge = 1'b0;
    endcase
  end

  // Set wins over any clear in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      compare_event_flag <= 1'b0;
    else if (hit_edge)
      compare_event_flag <= 1'b1;
    else if (irq_vector_ack_i)
      compare_event_flag <= 1'b0;
    else if ((wr_at(ACMP_OFS_CTRL_STATUS) && dat_i[ACMP_BIT_EVENT_FLAG])
          || (wr_at(ACMP_OFS_IRQ_STATUS) && dat_i[ACMP_BIT_IRQ_EVENT]))
      compare_event_flag <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Spurious irq on mode or power change is left to software
  assign irq_o = compare_event_flag && compare_irq_enable
              && global_irq_enable_i && irq_mask;
  assign capture_trigger_o = capture_route_enable
                          && compare_result;
  assign port_pin_read_o = synced[2:1] & ~input_buffer_disable;
  assign input_buffer_disable_o = input_buffer_disable;
  assign comparator_powered_o = !power_off;
  // Mux use relies on software keeping this low
  assign converter_power_reduce_o = converter_power_reduce;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_result_sync_delay: assert property (
    ##2 compare_result == $past(raw_result, 2))
    else $error("result not two cycles after raw");
  a_rise_sets_flag: assert property (
    compare_event_mode == ACMP_EV_RISE && $rose(compare_result)
    |=> compare_event_flag)
    else $error("rising edge did not set flag");
  a_fall_sets_flag: assert property (
    compare_event_mode == ACMP_EV_FALL && $fell(compare_result)
    |=> compare_event_flag)
    else $error("falling edge did not set flag");
  a_reserved_no_set: assert property (
    compare_event_mode == ACMP_EV_RESERVED && !compare_event_flag
    && $past(compare_event_mode) == ACMP_EV_RESERVED
    |=> !$rose(compare_event_flag))
    else $error("reserved mode set the flag");
  a_vector_clears: assert property (
    irq_vector_ack_i && !hit_edge |=> !compare_event_flag)
    else $error("vector entry kept flag");
  a_w1c_flag: assert property (
    wr_at(ACMP_OFS_CTRL_STATUS) && !dat_i[ACMP_BIT_EVENT_FLAG]
    && compare_event_flag && !irq_vector_ack_i |=> compare_event_flag)
    else $error("writing zero cleared flag");
  a_irq_gating: assert property (
    irq_o |-> compare_event_flag && compare_irq_enable
    && global_irq_enable_i)
    else $error("irq without its conditions");
  a_capture_route: assert property (
    !capture_route_enable |-> !capture_trigger_o)
    else $error("capture driven while routed off");
  a_buffer_masks_pin: assert property (
    input_buffer_disable[0] |-> !port_pin_read_o[0])
    else $error("disabled pin read as one");
  a_buffer_masks_neg: assert property (
    input_buffer_disable[1] |-> !port_pin_read_o[1])
    else $error("disabled negative pin read as one");
  a_ack_one_cycle: assert property (
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("ack not a single cycle");

  c_toggle_event: cover property (
    compare_event_mode == ACMP_EV_TOGGLE && hit_edge);
  c_irq_raised: cover property ($rose(irq_o));
  c_mux_channel: cover property (
    neg_input_mux_enable && !converter_enable && channel_select == 3'h7);

endmodule : acmp_top

// [tb/acmp_tb.sv]
// Self-checking bench for the analog comparator control block.
// Assumes acmp_pkg and acmp_top are compiled first; one 20 MHz clock.
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    checked++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); \
    end \
  end
module tb;
  import acmp_pkg::*;
  // ----------------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------------
  logic         clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
  logic [7:0]   adr_i;
  logic [3:0]   sel_i;
  logic [31:0]  dat_i, dat_o;
  acmp_analog_s analog_i;
  logic         pos_pin_digital_i, neg_pin_digital_i;
  logic [1:0]   port_pin_read_o, input_buffer_disable_o;
  logic         global_irq_enable_i, irq_vector_ack_i, irq_o;
  logic         capture_trigger_o, comparator_powered_o;
  logic         converter_power_reduce_o;
  logic [3:0]   wsel;
  int           checked, miscompares, cycles;

  acmp_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .analog_i(analog_i),
    .pos_pin_digital_i(pos_pin_digital_i),
    .neg_pin_digital_i(neg_pin_digital_i),
    .port_pin_read_o(port_pin_read_o),
    .input_buffer_disable_o(input_buffer_disable_o),
    .global_irq_enable_i(global_irq_enable_i),
    .irq_vector_ack_i(irq_vector_ack_i), .irq_o(irq_o),
    .capture_trigger_o(capture_trigger_o),
    .comparator_powered_o(comparator_powered_o),
    .converter_power_reduce_o(converter_power_reduce_o));

  // Free-running 50 ns clock
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // Watchdog; a hang counts as a mismatch
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      test_done();
    end
  end

  // ----------------------------------------------------------------------
  // Bus and helper tasks
  // ----------------------------------------------------------------------
  // One classic cycle; request held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= wsel;
    dat_i <= {24'h000000, d};
    // Only the watchdog ends a wait for ack
    do
    begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
    // Written value lands on the ack edge; let outputs settle
    @(posedge clk_i);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    bus(1'b0, a, 8'h00, q);
  endtask : rd

  // New levels, then enough edges for the synchroniser to settle
  task automatic set_an(input logic [9:0] p, input logic [9:0] n);
    @(posedge clk_i);
    analog_i.pos_level <= p;
    analog_i.neg_level <= n;
    repeat (4) @(posedge clk_i);
  endtask : set_an

  task automatic ctrl_bit(input int b, input logic e, input string nm);
    logic [7:0] q;
    // Result passes two sync flops after a select change
    repeat (2) @(posedge clk_i);
    rd(ACMP_OFS_CTRL_STATUS, q);
    `CHK(nm, e, q[b])
  endtask : ctrl_bit

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] ofs [7];
    logic [7:0] q;
    ofs = '{8'h50, 8'h54, 8'h58, 8'h5c, 8'h60, 8'h64, 8'h70};
    foreach (ofs[i])
    begin
      rd(ofs[i], q);
      `CHK("reset value", (i == 5) ? 8'h01 : ACMP_RST_REG8, q)
    end
    wsel = 4'h0;
    wr(ACMP_OFS_DIG_IN_DIS, 8'h03);
    wsel = 4'hf;
    rd(ACMP_OFS_DIG_IN_DIS, q);
    `CHK("masked write", 8'h00, q)
    `CHK("powered", 1'b1, comparator_powered_o)
    `CHK("irq idle", 1'b0, irq_o)
    $display("test reset done");
  endtask : t_reset

  task automatic t_compare();
    wr(ACMP_OFS_CTRL_STATUS, 8'h05);
    set_an(10'h200, 10'h200);
    ctrl_bit(ACMP_BIT_RESULT, 1'b0, "equal inputs");
    @(posedge clk_i);
    analog_i.neg_level <= 10'h1ff;
    repeat (2) @(posedge clk_i);
    #1 `CHK("capture", 1'b1, capture_trigger_o)
    ctrl_bit(ACMP_BIT_RESULT, 1'b1, "pos higher");
    wr(ACMP_OFS_CTRL_STATUS, 8'h01);
    #1 `CHK("route off", 1'b0, capture_trigger_o)
    $display("test compare done");
  endtask : t_compare

  task automatic t_bandgap();
    wr(ACMP_OFS_CTRL_STATUS, 8'h41);
    set_an(10'h000, ACMP_BANDGAP_LVL - 10'h001);
    ctrl_bit(ACMP_BIT_RESULT, 1'b1, "bandgap above");
    set_an(10'h3ff, ACMP_BANDGAP_LVL);
    ctrl_bit(ACMP_BIT_RESULT, 1'b0, "bandgap equal");
    wr(ACMP_OFS_CTRL_STATUS, 8'h01);
    set_an(10'h3ff, ACMP_BANDGAP_LVL);
    ctrl_bit(ACMP_BIT_RESULT, 1'b1, "pin used");
    $display("test bandgap done");
  endtask : t_bandgap

  task automatic t_mux();
    set_an(10'h200, 10'h3ff);
    wr(ACMP_OFS_CONV_CSR_B, 8'h40);
    for (int n = 0; n < 8; n++)
    begin
      @(posedge clk_i);
      for (int k = 0; k < 8; k++)
        analog_i.chan_level[k] <= (k == n) ? 10'h000 : 10'h3ff;
      wr(ACMP_OFS_CONV_BORROW, 8'(n));
      ctrl_bit(ACMP_BIT_RESULT, 1'b1, "channel pick");
    end
    wr(ACMP_OFS_CONV_BORROW, 8'h87);
    ctrl_bit(ACMP_BIT_RESULT, 1'b0, "converter on");
    wr(ACMP_OFS_CONV_BORROW, 8'h07);
    ctrl_bit(ACMP_BIT_RESULT, 1'b1, "mux again");
    wr(ACMP_OFS_CONV_CSR_B, 8'h00);
    ctrl_bit(ACMP_BIT_RESULT, 1'b0, "mux off");
    // Power-reduce only set while the mux is not in use
    wr(ACMP_OFS_CONV_BORROW, 8'h40);
    `CHK("power reduce", 1'b1, converter_power_reduce_o)
    wr(ACMP_OFS_CONV_BORROW, 8'h00);
    $display("test mux done");
  endtask : t_mux

  // Flag per mode: bit index is the mode code
  task automatic t_modes();
    logic [3:0] on_rise, on_fall;
    on_rise = 4'b1001;
    on_fall = 4'b0101;
    for (int m = 0; m < 4; m++)
    begin
      wr(ACMP_OFS_CTRL_STATUS, 8'h01);
      set_an(10'h100, 10'h200);
      wr(ACMP_OFS_CTRL_STATUS, 8'(m));
      wr(ACMP_OFS_IRQ_STATUS, 8'h01);
      set_an(10'h300, 10'h200);
      ctrl_bit(ACMP_BIT_EVENT_FLAG, on_rise[m], "rise flag");
      wr(ACMP_OFS_CTRL_STATUS, 8'(m));
      ctrl_bit(ACMP_BIT_EVENT_FLAG, on_rise[m], "zero keeps");
      wr(ACMP_OFS_IRQ_STATUS, 8'h01);
      ctrl_bit(ACMP_BIT_EVENT_FLAG, 1'b0, "set once");
      set_an(10'h100, 10'h200);
      ctrl_bit(ACMP_BIT_EVENT_FLAG, on_fall[m], "fall flag");
    end
    $display("test modes done");
  endtask : t_modes

  task automatic t_irq();
    wr(ACMP_OFS_CTRL_STATUS, 8'h01);
    set_an(10'h100, 10'h200);
    wr(ACMP_OFS_CTRL_STATUS, 8'h03);
    wr(ACMP_OFS_CTRL_STATUS, 8'h0b);
    wr(ACMP_OFS_IRQ_STATUS, 8'h01);
    set_an(10'h300, 10'h200);
    `CHK("global off", 1'b0, irq_o)
    global_irq_enable_i <= 1'b1;
    @(posedge clk_i);
    #1 `CHK("irq on", 1'b1, irq_o)
    wr(ACMP_OFS_IRQ_MASK, 8'h00);
    `CHK("masked", 1'b0, irq_o)
    wr(ACMP_OFS_IRQ_MASK, 8'h01);
    `CHK("unmasked", 1'b1, irq_o)
    irq_vector_ack_i <= 1'b1;
    @(posedge clk_i);
    irq_vector_ack_i <= 1'b0;
    @(posedge clk_i);
    #1 `CHK("vector clear", 1'b0, irq_o)
    set_an(10'h100, 10'h200);
    set_an(10'h300, 10'h200);
    `CHK("irq again", 1'b1, irq_o)
    wr(ACMP_OFS_CTRL_STATUS, 8'h1b);
    `CHK("w1c clear", 1'b0, irq_o)
    global_irq_enable_i <= 1'b0;
    wr(ACMP_OFS_CTRL_STATUS, 8'h03);
    wr(ACMP_OFS_CTRL_STATUS, 8'h01);
    $display("test irq done");
  endtask : t_irq

  task automatic t_power_pins();
    set_an(10'h300, 10'h100);
    wr(ACMP_OFS_CTRL_STATUS, 8'h81);
    `CHK("powered off", 1'b0, comparator_powered_o)
    set_an(10'h300, 10'h100);
    ctrl_bit(ACMP_BIT_RESULT, 1'b0, "off result");
    wr(ACMP_OFS_CTRL_STATUS, 8'h01);
    set_an(10'h300, 10'h100);
    ctrl_bit(ACMP_BIT_RESULT, 1'b1, "on result");
    `CHK("pins read", 2'b11, port_pin_read_o)
    wr(ACMP_OFS_DIG_IN_DIS, 8'h01);
    `CHK("pos off", 2'b01, input_buffer_disable_o)
    `CHK("pos reads 0", 2'b10, port_pin_read_o)
    wr(ACMP_OFS_DIG_IN_DIS, 8'h02);
    `CHK("neg reads 0", 2'b01, port_pin_read_o)
    $display("test power and pins done");
  endtask : t_power_pins

  task automatic test_done();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done

  // Main sequence; pins held high so buffer gating shows
  initial
  begin
    {cyc_i, stb_i, we_i, irq_vector_ack_i, global_irq_enable_i} = '0;
    {adr_i, dat_i, analog_i} = '0;
    sel_i = 4'hf;
    wsel = 4'hf;
    pos_pin_digital_i = 1'b1;
    neg_pin_digital_i = 1'b1;
    rst_i = 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_compare();
    t_bandgap();
    t_mux();
    t_modes();
    t_irq();
    t_power_pins();
    test_done();
  end
endmodule : tb
